// [hw/mics_pkg.sv]
/*
  shared constants and carrier types for the main interrupt and
  shutdown/clock control block.
  assumes a 50 MHz system clock and a 32-bit avalon-mm register bus.
*/
package mics_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SRC_A  = 16'hffe0;
  localparam logic [15:0] IDX_SRC_B  = 16'hffe1;
  localparam logic [15:0] IDX_MSK_A  = 16'hffe2;
  localparam logic [15:0] IDX_MSK_B  = 16'hffe3;
  localparam logic [15:0] IDX_CTL    = 16'hffe9;
  localparam logic [15:0] IDX_UNLOCK = 16'hffea;

  localparam int ADDR_W = 18;

  // writable (non-reserved) mask bits
  localparam logic [7:0] MSK_A_WR  = 8'h3f;
  localparam logic [7:0] MSK_B_WR  = 8'h7d;
  localparam logic [7:0] MSK_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // source bit positions
  localparam int A_JIT  = 5;
  localparam int A_EXTC = 4;
  localparam int A_EXTB = 3;
  localparam int A_TXE  = 2;
  localparam int A_RXE  = 1;
  localparam int A_RXF  = 0;
  localparam int B_P1C  = 6;
  localparam int B_P1B  = 5;
  localparam int B_P1A  = 4;
  localparam int B_MS   = 3;
  localparam int B_SIO  = 2;
  localparam int B_EXTA = 0;

  // shutdown delay window
  localparam longint CLK_MHZ     = 50;
  localparam longint SHUT_MIN_NS = 3560000;
  localparam longint SHUT_MAX_NS = 7120000;
  localparam longint SHUT_MIN_CYCLES = (SHUT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam longint SHUT_MAX_CYCLES = (SHUT_MAX_NS * CLK_MHZ) / 1000;
  localparam int SHUT_CNT_W = 20;

  // processor clock synthesis: code 0 is the top rate, each step halves
  localparam logic [26:0] CLK_HZ     = 27'h2faf080;
  localparam logic [26:0] CPU_TOP_HZ = 27'h08ca000;
  localparam logic [2:0]  RATE_TOP   = 3'h0;

  typedef struct packed {
    logic shut;
    logic auto_speedup;
    logic [2:0] rsvd;
    logic [2:0] rate;
  } mics_ctl_t;

  typedef struct packed {
    logic tx_half_empty;
    logic rx_full;
    logic tx_empty;
    logic rx_error;
    logic rx_half_full;
  } mics_dch_t;

  typedef enum {
    UNLK_IDLE,
    UNLK_KEY1,
    UNLK_CTL1,
    UNLK_KEY2
  } mics_unlk_t;

endpackage

// [hw/mics_top.sv]
/*
  main interrupt aggregation, timed shutdown request and processor
  clock rate control, with an avalon-mm register slave.
  assumes source units on the same clock deliver pending levels and
  clear-on-read strobes; external irq pins are asynchronous.
*/
// How it works
// - any source a bit drives line a low
// - any source b bit drives line b low
// - source bit is pending and mask, except the a5 noise term; masks reset zero
// - reserved source and mask bits read zero
// - bit a5 ors gated jitter and noise terms
// - pin c edge sets a4; status read clears
// - pin b edge sets a3; status read clears
// - a2 is tx empty, half-empty when double buffered
// - a1 is receive parity, crc or overflow error
// - a0 is receive buffer holding code words
// - b6 follows port1 pins 7 to 4 event
// - b5 follows port1 pins 3 and 2 event
// - b4 follows port1 pins 1 and 0 event
// - b3 ors the four marker/sync sources
// - b2 ors the two serial port sources
// - pin a edge sets b0; status read clears
// - control writes need unlock; reads always allowed
// - shut bit starts or restarts delay; zero halts
// - unmasked irq aborts shutdown; exit clears bit
// - auto speedup raises processor clock to top
// - rate field picks clock; loaded by write, cleared by speedup
// - unlock, control, unlock, data; other access aborts
// - code zero is top rate, each step halves
`timescale 1ns/1ps
`default_nettype none

module mics_top #(
  parameter int unsigned SHUT_DELAY_CYCLES = 32'(mics_pkg::SHUT_MIN_CYCLES)
) (
  input  wire logic                        REF_CLK_I,
  input  wire logic                        SYS_RST_I,
  // avalon-mm slave
  input  wire logic [mics_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                        AVS_READ_I,
  input  wire logic                        AVS_WRITE_I,
  input  wire logic [3:0]                  AVS_BYTEENABLE_I,
  input  wire logic [31:0]                 AVS_WRITEDATA_I,
  output logic [31:0]                      AVS_READDATA_O,
  output logic                             AVS_WAITREQUEST_O,
  // asynchronous external interrupt pins a, b, c
  input  wire logic [2:0]                  EXTERNAL_IRQ_PIN_I,
  // clear-on-read strobes of the external irq status registers
  input  wire logic [2:0]                  EXTERNAL_IRQ_STATUS_RD_I,
  // pending levels from the source units
  input  wire logic                        JITTER_STATUS_I,
  input  wire logic                        NOISE_STATUS_I,
  input  wire logic                        NOISE_MASK_I,
  input  wire mics_pkg::mics_dch_t         DCH_BUFFER_STATUS_I,
  input  wire logic                        DOUBLE_BUFFER_MODE_I,
  input  wire logic [2:0]                  PORT1_GROUP_IRQ_I,
  input  wire logic [3:0]                  MARKER_SYNC_IRQ_I,
  input  wire logic [1:0]                  SERIAL_PORT_IRQ_I,
  // processor side
  output logic                             CPU_IRQ_LINE_A_N_O,
  output logic                             CPU_IRQ_LINE_B_N_O,
  output logic                             SHUTDOWN_O,
  output logic [2:0]                       CPU_CLK_RATE_O,
  output logic                             PROCESSOR_CLOCK_EN_O
);

  function automatic logic idx_hit(input logic [15:0] idx,
                                   input logic [15:0] want);
    idx_hit = (idx == want);
  endfunction

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic [15:0]         word_idx;
  logic                bus_req;
  logic                bus_done;
  logic                wr_done;
  logic                rd_done;
  logic                lane0;
  logic                hit_src_a;
  logic                hit_src_b;
  logic                hit_msk_a;
  logic                hit_msk_b;
  logic                hit_ctl;
  logic                hit_unlock;
  logic [7:0]          rd_byte;

  assign word_idx   = AVS_ADDRESS_I[mics_pkg::ADDR_W-1:2];
  assign bus_req    = AVS_READ_I | AVS_WRITE_I;
  // the request completes at the edge that samples waitrequest low
  assign bus_done   = bus_req & ~AVS_WAITREQUEST_O;
  assign wr_done    = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
  assign rd_done    = AVS_READ_I & ~AVS_WAITREQUEST_O;
  assign lane0      = AVS_BYTEENABLE_I[0];
  assign hit_src_a  = idx_hit(word_idx, mics_pkg::IDX_SRC_A);
  assign hit_src_b  = idx_hit(word_idx, mics_pkg::IDX_SRC_B);
  assign hit_msk_a  = idx_hit(word_idx, mics_pkg::IDX_MSK_A);
  assign hit_msk_b  = idx_hit(word_idx, mics_pkg::IDX_MSK_B);
  assign hit_ctl    = idx_hit(word_idx, mics_pkg::IDX_CTL);
  assign hit_unlock = idx_hit(word_idx, mics_pkg::IDX_UNLOCK);

  // ------------------------------------------------------------------
  // external irq pins: synchronise, detect any change, hold pending
  // ------------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_last;
  logic [2:0] ext_pend;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ext
      logic pin_edge;
      assign pin_edge = pin_sync[g] ^ pin_last[g];

      always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
      begin
        if (SYS_RST_I)
        begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
          pin_last[g] <= 1'b0;
          ext_pend[g] <= 1'b0;
        end
        else
        begin
          pin_meta[g] <= EXTERNAL_IRQ_PIN_I[g];
          pin_sync[g] <= pin_meta[g];
          pin_last[g] <= pin_sync[g];
          // a change in the clearing cycle is kept: set wins
          if (pin_edge)
            ext_pend[g] <= 1'b1;
          else if (EXTERNAL_IRQ_STATUS_RD_I[g])
            ext_pend[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // mask registers and source composition
  // ------------------------------------------------------------------
  logic [7:0] mask_a;
  logic [7:0] mask_b;
  logic [7:0] pend_a;
  logic [7:0] pend_b;
  logic [7:0] next_source_a;
  logic [7:0] next_source_b;
  logic [7:0] source_a;
  logic [7:0] source_b;
  logic       noise_term;
  logic       irq_any;

  // the noise term has its own mask in the noise unit, so it bypasses
  // the main mask; jitter is cleared there when noise control is read
  assign noise_term = NOISE_STATUS_I & NOISE_MASK_I;

  always_comb
  begin
    pend_a = 8'h00;
    pend_a[mics_pkg::A_JIT]  = JITTER_STATUS_I;
    pend_a[mics_pkg::A_EXTC] = ext_pend[2];
    pend_a[mics_pkg::A_EXTB] = ext_pend[1];
    pend_a[mics_pkg::A_TXE]  = DCH_BUFFER_STATUS_I.tx_empty |
                               (DOUBLE_BUFFER_MODE_I &
                                DCH_BUFFER_STATUS_I.tx_half_empty);
    pend_a[mics_pkg::A_RXE]  = DCH_BUFFER_STATUS_I.rx_error;
    pend_a[mics_pkg::A_RXF]  = DCH_BUFFER_STATUS_I.rx_half_full |
                               (DOUBLE_BUFFER_MODE_I &
                                DCH_BUFFER_STATUS_I.rx_full);
    pend_b = 8'h00;
    pend_b[mics_pkg::B_P1C]  = PORT1_GROUP_IRQ_I[2];
    pend_b[mics_pkg::B_P1B]  = PORT1_GROUP_IRQ_I[1];
    pend_b[mics_pkg::B_P1A]  = PORT1_GROUP_IRQ_I[0];
    pend_b[mics_pkg::B_MS]   = |MARKER_SYNC_IRQ_I;
    pend_b[mics_pkg::B_SIO]  = |SERIAL_PORT_IRQ_I;
    pend_b[mics_pkg::B_EXTA] = ext_pend[0];
  end

  // reserved positions carry no pending and no mask, so read zero
  assign next_source_a = ((pend_a & mask_a) |
                          ({7'h00, noise_term} << mics_pkg::A_JIT)) &
                         mics_pkg::MSK_A_WR;
  assign next_source_b = pend_b & mask_b &
                         mics_pkg::MSK_B_WR;
  assign irq_any = (|source_a) | (|source_b);

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      mask_a <= mics_pkg::MSK_RESET;
      mask_b <= mics_pkg::MSK_RESET;
    end
    else if (wr_done & lane0)
    begin
      if (hit_msk_a)
        mask_a <= AVS_WRITEDATA_I[7:0] & mics_pkg::MSK_A_WR;
      if (hit_msk_b)
        mask_b <= AVS_WRITEDATA_I[7:0] & mics_pkg::MSK_B_WR;
    end
  end

  // sources are rebuilt every cycle; bus writes never reach them
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      source_a           <= 8'h00;
      source_b           <= 8'h00;
      CPU_IRQ_LINE_A_N_O <= 1'b1;
      CPU_IRQ_LINE_B_N_O <= 1'b1;
    end
    else
    begin
      source_a           <= next_source_a;
      source_b           <= next_source_b;
      CPU_IRQ_LINE_A_N_O <= ~(|next_source_a);
      CPU_IRQ_LINE_B_N_O <= ~(|next_source_b);
    end
  end

  // ------------------------------------------------------------------
  // protected control register
  // ------------------------------------------------------------------
  mics_pkg::mics_unlk_t unlk;
  mics_pkg::mics_unlk_t next_unlk;
  mics_pkg::mics_ctl_t  ctl;
  logic                 ctl_commit;
  logic                 wr_unlock;
  logic                 wr_ctl;

  assign wr_unlock  = wr_done & hit_unlock;
  assign wr_ctl     = wr_done & hit_ctl;
  assign ctl_commit = (unlk == mics_pkg::UNLK_KEY2) & wr_ctl &
                      lane0;

  // any completed access that does not continue the key sequence
  // drops back; a fresh unlock write always restarts it
  always_comb
  begin
    next_unlk = unlk;
    if (bus_done)
    begin
      case (unlk)
        mics_pkg::UNLK_IDLE:
          next_unlk = wr_unlock ? mics_pkg::UNLK_KEY1
                                : mics_pkg::UNLK_IDLE;
        mics_pkg::UNLK_KEY1:
          next_unlk = wr_ctl ? mics_pkg::UNLK_CTL1
                    : (wr_unlock ? mics_pkg::UNLK_KEY1
                                 : mics_pkg::UNLK_IDLE);
        mics_pkg::UNLK_CTL1:
          next_unlk = wr_unlock ? mics_pkg::UNLK_KEY2
                                : mics_pkg::UNLK_IDLE;
        mics_pkg::UNLK_KEY2:
          next_unlk = wr_unlock ? mics_pkg::UNLK_KEY1
                                : mics_pkg::UNLK_IDLE;
        default:
          next_unlk = mics_pkg::UNLK_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      unlk <= mics_pkg::UNLK_IDLE;
    else
      unlk <= next_unlk;
  end

  // ------------------------------------------------------------------
  // shutdown timer
  // ------------------------------------------------------------------
  localparam logic [mics_pkg::SHUT_CNT_W-1:0] SHUT_LOAD =
    mics_pkg::SHUT_CNT_W'(SHUT_DELAY_CYCLES);
  localparam logic [mics_pkg::SHUT_CNT_W-1:0] CNT_ONE =
    mics_pkg::SHUT_CNT_W'(1);

  logic [mics_pkg::SHUT_CNT_W-1:0] shut_cnt;
  logic                            shut_expire;

  assign shut_expire = ctl.shut & ~SHUTDOWN_O & (shut_cnt == CNT_ONE);

  // an unmasked interrupt beats a same-cycle write of the shut bit,
  // so software cannot enter shutdown over a pending interrupt
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      ctl        <= mics_pkg::CTL_RESET;
      shut_cnt   <= '0;
      SHUTDOWN_O <= 1'b0;
    end
    else
    begin
      if (ctl_commit)
      begin
        ctl.shut         <= AVS_WRITEDATA_I[7];
        ctl.auto_speedup <= AVS_WRITEDATA_I[6];
        ctl.rate         <= AVS_WRITEDATA_I[2:0];
        shut_cnt         <= SHUT_LOAD;
      end
      else if (shut_cnt != '0)
        shut_cnt <= shut_cnt - CNT_ONE;
      if (shut_expire)
        SHUTDOWN_O <= 1'b1;
      if (irq_any)
      begin
        ctl.shut   <= 1'b0;
        SHUTDOWN_O <= 1'b0;
        shut_cnt   <= '0;
        if (ctl.auto_speedup)
          ctl.rate <= mics_pkg::RATE_TOP;
      end
    end
  end

  // ------------------------------------------------------------------
  // processor clock enable: phase accumulator, top rate >> code
  // ------------------------------------------------------------------
  logic [26:0] phase;
  logic [26:0] step;
  logic [26:0] phase_sum;
  logic        phase_wrap;

  assign step       = mics_pkg::CPU_TOP_HZ >> ctl.rate;
  assign phase_sum  = phase + step;
  assign phase_wrap = phase_sum >= mics_pkg::CLK_HZ;

  // the enable is stopped while shut down; jitter is one system clock
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      phase                <= '0;
      PROCESSOR_CLOCK_EN_O <= 1'b0;
      CPU_CLK_RATE_O       <= mics_pkg::RATE_TOP;
    end
    else
    begin
      CPU_CLK_RATE_O <= ctl.rate;
      if (SHUTDOWN_O)
      begin
        phase                <= '0;
        PROCESSOR_CLOCK_EN_O <= 1'b0;
      end
      else
      begin
        phase <= phase_wrap ? phase_sum - mics_pkg::CLK_HZ
                            : phase_sum;
        PROCESSOR_CLOCK_EN_O <= phase_wrap;
      end
    end
  end

  // ------------------------------------------------------------------
  // read mux and waitrequest: one wait state per access
  // ------------------------------------------------------------------
  assign rd_byte = hit_src_a ? source_a
                 : hit_src_b ? source_b
                 : hit_msk_a ? mask_a
                 : hit_msk_b ? mask_b
                 : hit_ctl   ? {ctl.shut, ctl.auto_speedup, 3'h0,
                                ctl.rate}
                 : 8'h00;

  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0000_0000;
    end
    else if (bus_req & AVS_WAITREQUEST_O)
    begin
      AVS_WAITREQUEST_O <= 1'b0;
      AVS_READDATA_O    <= AVS_READ_I ? {24'h00_0000, rd_byte}
                                      : 32'h0000_0000;
    end
    else
    begin
      AVS_WAITREQUEST_O <= 1'b1;
      if (rd_done)
        AVS_READDATA_O <= AVS_READDATA_O;
    end
  end

endmodule // mics_top

`default_nettype wire

// [sim/mics_top_asserts.sv]
/*
  port checker for mics_top, bound into every instance.
  assumes one clock domain and the one-cycle bus answer of the slave.
*/
`timescale 1ns/1ps
`default_nettype none

module mics_top_chk #(
  parameter int unsigned SHUT_DELAY_CYCLES = 20
) (
  input wire logic        REF_CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic [17:0] AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        CPU_IRQ_LINE_A_N_O,
  input wire logic        CPU_IRQ_LINE_B_N_O,
  input wire logic        SHUTDOWN_O,
  input wire logic [2:0]  CPU_CLK_RATE_O,
  input wire logic        PROCESSOR_CLOCK_EN_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  logic [15:0] idx;
  logic        rd_done;
  logic        wr_done;
  logic [31:0] since_shut;

  assign idx     = AVS_ADDRESS_I[17:2];
  assign rd_done = AVS_READ_I && !AVS_WAITREQUEST_O;
  assign wr_done = AVS_WRITE_I && !AVS_WAITREQUEST_O;

  // saturates so a long idle stretch never wraps to a false small count
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      since_shut <= 32'h0;
    else if (wr_done && idx == mics_pkg::IDX_CTL && AVS_WRITEDATA_I[7])
      since_shut <= 32'h0;
    else if (since_shut != 32'hffffffff)
      since_shut <= since_shut + 32'h1;
  end

  sequence s_req;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence

  a_bus_answers: assert property (
    s_req |=> !AVS_WAITREQUEST_O) else $error("bus request not answered");
  a_rsvd_a_zero: assert property (
    rd_done && (idx == mics_pkg::IDX_SRC_A || idx == mics_pkg::IDX_MSK_A)
    |-> AVS_READDATA_O[7:6] == 2'h0) else $error("reserved a bits set");
  a_rsvd_b_zero: assert property (
    rd_done && (idx == mics_pkg::IDX_SRC_B || idx == mics_pkg::IDX_MSK_B)
    |-> !AVS_READDATA_O[7] && !AVS_READDATA_O[1])
    else $error("reserved b bits set");
  a_line_a_src: assert property (
    rd_done && idx == mics_pkg::IDX_SRC_A && AVS_READDATA_O[7:0] != 8'h00
    |-> !CPU_IRQ_LINE_A_N_O || !$past(CPU_IRQ_LINE_A_N_O))
    else $error("line a idle with source a set");
  a_line_b_src: assert property (
    rd_done && idx == mics_pkg::IDX_SRC_B && AVS_READDATA_O[7:0] != 8'h00
    |-> !CPU_IRQ_LINE_B_N_O || !$past(CPU_IRQ_LINE_B_N_O))
    else $error("line b idle with source b set");
  a_irq_wakes: assert property (
    (!CPU_IRQ_LINE_A_N_O || !CPU_IRQ_LINE_B_N_O) |=> !SHUTDOWN_O)
    else $error("shutdown held during interrupt");
  a_shut_delay: assert property (
    $rose(SHUTDOWN_O) |-> since_shut >= SHUT_DELAY_CYCLES - 1)
    else $error("shutdown entered too early");
  a_rate_cause: assert property (
    !$stable(CPU_CLK_RATE_O) |-> $past(wr_done) || $past(wr_done, 2)
    || CPU_CLK_RATE_O == 3'h0) else $error("rate changed without cause");
  a_no_clk_shut: assert property (
    SHUTDOWN_O && $past(SHUTDOWN_O) |-> !PROCESSOR_CLOCK_EN_O)
    else $error("clock enable during shutdown");
endmodule // mics_top_chk

bind mics_top mics_top_chk #(
  .SHUT_DELAY_CYCLES(SHUT_DELAY_CYCLES)
) u_mics_top_chk (
  .REF_CLK_I            (REF_CLK_I),
  .SYS_RST_I            (SYS_RST_I),
  .AVS_ADDRESS_I        (AVS_ADDRESS_I),
  .AVS_READ_I           (AVS_READ_I),
  .AVS_WRITE_I          (AVS_WRITE_I),
  .AVS_WRITEDATA_I      (AVS_WRITEDATA_I),
  .AVS_READDATA_O       (AVS_READDATA_O),
  .AVS_WAITREQUEST_O    (AVS_WAITREQUEST_O),
  .CPU_IRQ_LINE_A_N_O   (CPU_IRQ_LINE_A_N_O),
  .CPU_IRQ_LINE_B_N_O   (CPU_IRQ_LINE_B_N_O),
  .SHUTDOWN_O           (SHUTDOWN_O),
  .CPU_CLK_RATE_O       (CPU_CLK_RATE_O),
  .PROCESSOR_CLOCK_EN_O (PROCESSOR_CLOCK_EN_O)
);

`default_nettype wire

// [sim/mics_src_model.sv]
/*
  model of the source units: events latch into pending levels until
  the matching clear strobe. assumes the system clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module mics_src_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] set_i,
  input  wire logic [15:0] clr_i,
  output logic      [15:0] lvl_o
);
  // set wins so an event landing on the read cycle is not lost
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      lvl_o <= 16'h0000;
    else
      lvl_o <= (lvl_o & ~clr_i) | set_i;
  end
endmodule // mics_src_model

`default_nettype wire

// [sim/test_main_irq_and_shutdown_ctl.sv]
/*
  self-checking bench for mics_top with the source-unit model.
  assumes the bound checker and a short shutdown delay parameter.
*/
`timescale 1ns/1ps
`default_nettype none

module test_main_irq_and_shutdown_ctl;
  localparam int DLY = 20;
  localparam logic [17:0] SA = 18'h3ff80;
  localparam logic [17:0] SB = 18'h3ff84;
  localparam logic [17:0] MA = 18'h3ff88;
  localparam logic [17:0] MB = 18'h3ff8c;
  localparam logic [17:0] CT = 18'h3ffa4;
  localparam logic [17:0] UN = 18'h3ffa8;
  localparam logic [15:0] EV [14] = '{16'h0001, 16'h0002, 16'h0004,
    16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0080, 16'h0100,
    16'h0200, 16'h0400, 16'h2000, 16'h4000, 16'h8000};
  localparam logic [7:0] EA [14] = '{8'h20, 8'h00, 8'h01, 8'h02, 8'h04,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] EB [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h10, 8'h20, 8'h40, 8'h08, 8'h08, 8'h04, 8'h04};

  logic        clk;
  logic        rst;
  logic [17:0] addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitr;
  logic [2:0]  pin;
  logic [2:0]  st_rd;
  logic        nmask;
  logic        dbuf;
  logic [15:0] ev_set;
  logic [15:0] ev_clr;
  logic [15:0] lvl;
  logic        line_a;
  logic        line_b;
  logic        shut;
  logic [2:0]  rate;
  logic        clk_en;
  int          err_total;
  int          comparisons;
  int          cyc;

  mics_top #(.SHUT_DELAY_CYCLES(DLY)) u_mics_top (
    .REF_CLK_I                (clk),
    .SYS_RST_I                (rst),
    .AVS_ADDRESS_I            (addr),
    .AVS_READ_I               (rd),
    .AVS_WRITE_I              (wr),
    .AVS_BYTEENABLE_I         (4'h1),
    .AVS_WRITEDATA_I          (wdata),
    .AVS_READDATA_O           (rdata),
    .AVS_WAITREQUEST_O        (waitr),
    .EXTERNAL_IRQ_PIN_I       (pin),
    .EXTERNAL_IRQ_STATUS_RD_I (st_rd),
    .JITTER_STATUS_I          (lvl[0]),
    .NOISE_STATUS_I           (lvl[1]),
    .NOISE_MASK_I             (nmask),
    .DCH_BUFFER_STATUS_I      (mics_pkg::mics_dch_t'(lvl[6:2])),
    .DOUBLE_BUFFER_MODE_I     (dbuf),
    .PORT1_GROUP_IRQ_I        (lvl[9:7]),
    .MARKER_SYNC_IRQ_I        (lvl[13:10]),
    .SERIAL_PORT_IRQ_I        (lvl[15:14]),
    .CPU_IRQ_LINE_A_N_O       (line_a),
    .CPU_IRQ_LINE_B_N_O       (line_b),
    .SHUTDOWN_O               (shut),
    .CPU_CLK_RATE_O           (rate),
    .PROCESSOR_CLOCK_EN_O     (clk_en)
  );

  mics_src_model u_mics_src_model (
    .clk_i (clk),
    .rst_i (rst),
    .set_i (ev_set),
    .clr_i (ev_clr),
    .lvl_o (lvl)
  );

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [17:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h000000, d};
    // no cycle limit here: the bench timeout ends a hung access
    do
      @(posedge clk);
    while (waitr !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrt(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [17:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic unl(input logic [7:0] d);
    wrt(UN, 8'h00);
    wrt(CT, 8'h00);
    wrt(UN, 8'h00);
    wrt(CT, d);
  endtask

  task automatic src(input logic [15:0] s, input logic [15:0] c);
    ev_set <= s;
    ev_clr <= c;
    @(posedge clk);
    ev_set <= 16'h0000;
    ev_clr <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask

  task automatic cnt_en(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (clk_en === 1'b1)
        c++;
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    int c;
    logic [7:0] q;
    {rst, rd, wr, addr, wdata, pin, st_rd} = {1'b1, 58'h0};
    {nmask, dbuf, ev_set, ev_clr, err_total, comparisons, cyc} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(MA, mics_pkg::MSK_RESET);
    rdc(MB, mics_pkg::MSK_RESET);
    rdc(CT, mics_pkg::CTL_RESET);
    rdc(18'h3ff90, 8'h00);
    cnt_en(1000, c);
    chk((c >= 184 && c <= 185) ? 8'h01 : 8'h00, 8'h01);
    src(16'hfffd, 16'h0000);
    rdc(SA, 8'h00);
    rdc(SB, 8'h00);
    chk({6'h00, line_a, line_b}, 8'h03);
    wrt(MA, 8'hff);
    wrt(MB, 8'hff);
    wrt(SA, 8'hff);
    rdc(MA, 8'h3f);
    rdc(MB, 8'h7d);
    rdc(SA, 8'h27);
    rdc(SB, 8'h7c);
    chk({6'h00, line_a, line_b}, 8'h00);
    src(16'h0000, 16'hffff);
    chk({6'h00, line_a, line_b}, 8'h03);
    for (int i = 0; i < 14; i++)
    begin
      src(EV[i], 16'h0000);
      rdc(SA, EA[i]);
      rdc(SB, EB[i]);
      src(16'h0000, EV[i]);
    end
    dbuf <= 1'b1;
    nmask <= 1'b1;
    src(16'h0062, 16'h0000);
    rdc(SA, 8'h25);
    wrt(MA, 8'h1f);
    src(16'h0001, 16'h0000);
    rdc(SA, 8'h25);
    nmask <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(SA, 8'h05);
    src(16'h0000, 16'hffff);
    rdc(SA, 8'h00);
    wrt(MA, 8'hff);
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 2; j++)
      begin
        pin[i] <= ~pin[i];
        repeat (6) @(posedge clk);
        rdc(i == 0 ? SB : SA, i == 0 ? 8'h01 : 8'h04 << i);
        st_rd[i] <= 1'b1;
        @(posedge clk);
        st_rd <= 3'h0;
        repeat (3) @(posedge clk);
        rdc(i == 0 ? SB : SA, 8'h00);
      end
    wrt(CT, 8'h45);
    rdc(CT, 8'h00);
    wrt(UN, 8'h00);
    wrt(CT, 8'h00);
    bus(1'b0, SA, 8'h00, q);
    wrt(UN, 8'h00);
    wrt(CT, 8'h45);
    rdc(CT, 8'h00);
    unl(8'h03);
    cnt_en(1000, c);
    chk((c >= 23 && c <= 24) ? 8'h01 : 8'h00, 8'h01);
    chk({5'h00, rate}, 8'h03);
    unl(8'h7d);
    rdc(CT, 8'h45);
    src(16'h0080, 16'h0000);
    rdc(CT, 8'h40);
    chk({5'h00, rate}, 8'h00);
    src(16'h0000, 16'hffff);
    unl(8'h80);
    repeat (DLY - 3) @(posedge clk);
    chk({7'h00, shut}, 8'h00);
    repeat (6) @(posedge clk);
    chk({7'h00, shut}, 8'h01);
    rdc(CT, 8'h80);
    src(16'h0010, 16'h0000);
    chk({7'h00, shut}, 8'h00);
    rdc(CT, 8'h00);
    src(16'h0000, 16'hffff);
    unl(8'h80);
    repeat (2) @(posedge clk);
    unl(8'h80);
    repeat (DLY - 3) @(posedge clk);
    chk({7'h00, shut}, 8'h00);
    repeat (6) @(posedge clk);
    chk({7'h00, shut}, 8'h01);
    src(16'h0010, 16'hffff);
    src(16'h0000, 16'hffff);
    unl(8'h80);
    unl(8'h00);
    repeat (DLY + 10) @(posedge clk);
    chk({7'h00, shut}, 8'h00);
    rdc(CT, 8'h00);
    close_out();
  end
endmodule // test_main_irq_and_shutdown_ctl

`default_nettype wire
